// ### sxs_consts.svh
// What this block does
// - Literal-minus-accumulator writes the literal minus the accumulator into the accumulator.
// - A subtraction without borrow-in clears carry when the accumulator exceeds the other operand, else sets it.
// - Sleep clears the power-down status bit, sets the time-out status bit, and touches no flag.
// - Sleep resets the watchdog counter to zero and clears its prescaler.
// - Sleep puts the core into the low-power state with its oscillator halted.
// - Register-minus-accumulator subtracts the accumulator from file register 0..127.
// - Subtract with borrow also takes away the inverted carry, and updates carry, digit, zero.
// - Nibble swap exchanges the two halves of the file register and leaves all flags alone.
// - A destination bit of zero sends the result to the accumulator, one to the file register.
// - Literal exclusive-OR writes accumulator XOR literal to the accumulator, zero flag only.
// - Direction load copies the accumulator to port A, B or C direction for operand 5, 6, 7.
// - Register exclusive-OR sends accumulator XOR file register to the destination, zero only.
`ifndef SXS_CONSTS_SVH
`define SXS_CONSTS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define SXS_OFF_ACC       12'h000
`define SXS_OFF_STATUS    12'h004
`define SXS_OFF_INSTR     12'h008
`define SXS_OFF_DIR_A     12'h00C
`define SXS_OFF_DIR_B     12'h010
`define SXS_OFF_DIR_C     12'h014
`define SXS_OFF_WDOG      12'h018
`define SXS_OFF_PWR       12'h01C
`define SXS_FILE_REGION   3'h1

// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define SXS_ST_CARRY      0
`define SXS_ST_DIGIT      1
`define SXS_ST_ZERO       2
`define SXS_ST_PWRDN      3
`define SXS_ST_TMOUT      4
`define SXS_IN_DEST       7
`define SXS_IN_F_LSB      8
`define SXS_IN_K_LSB      16
`define SXS_PWR_WAKE      0
`define SXS_PWR_SLEEP     1

// ----------------------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------------------
`define SXS_OP_NOP        4'h0
`define SXS_OP_LITSUB     4'h1
`define SXS_OP_REGSUB     4'h2
`define SXS_OP_REGSUBB    4'h3
`define SXS_OP_SWAP       4'h4
`define SXS_OP_XORLIT     4'h5
`define SXS_OP_XORREG     4'h6
`define SXS_OP_DIRLOAD    4'h7
`define SXS_OP_SLEEP      4'h8
`define SXS_SEL_DIR_A     7'h05
`define SXS_SEL_DIR_B     7'h06
`define SXS_SEL_DIR_C     7'h07
`define SXS_RST_BYTE      8'h00
`define SXS_RST_DIR       8'hFF
`define SXS_RST_TMOUT     1'b1
`define SXS_RST_PWRDN     1'b1
`define SXS_WDOG_PRE_LAST 8'hFF
`define SXS_RESP_OKAY     2'h0
`define SXS_RESP_DECERR   2'h3

`endif

// ### sxs_exec.sv
// Implementation choices: the address map and register access over AXI4-Lite.
`default_nettype none
`include "sxs_consts.svh"

module sxs_exec import sxs_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        wakeRequest,
  output logic             oscRun,
  output logic [7:0]       portADir,
  output logic [7:0]       portBDir,
  output logic [7:0]       portCDir
);

  // --------------------------------------------------------------------------
  // bus write channel capture
  // --------------------------------------------------------------------------
  logic        awHeld_r;
  logic [11:0] awAddr_r;
  logic        wHeld_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        bValid_r;
  logic [1:0]  bResp_r;
  logic        rValid_r;
  logic [31:0] rData_r;
  logic [1:0]  rResp_r;

  logic        doWrite;
  logic        arTake;
  assign s_axi_awready = ~awHeld_r;
  assign s_axi_wready  = ~wHeld_r;
  assign s_axi_arready = ~rValid_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;
  assign doWrite       = awHeld_r & wHeld_r & ~bValid_r;
  assign arTake        = s_axi_arvalid & ~rValid_r;

  // --------------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------------
  logic selAcc, selStatus, selInstr, selPwr, selFile, selRo, wMapped, lane0, laneInstr;
  assign selAcc    = awAddr_r == `SXS_OFF_ACC;
  assign selStatus = awAddr_r == `SXS_OFF_STATUS;
  assign selInstr  = awAddr_r == `SXS_OFF_INSTR;
  assign selPwr    = awAddr_r == `SXS_OFF_PWR;
  assign selFile   = awAddr_r[11:9] == `SXS_FILE_REGION;
  assign selRo     = (awAddr_r == `SXS_OFF_DIR_A) | (awAddr_r == `SXS_OFF_DIR_B)
                   | (awAddr_r == `SXS_OFF_DIR_C) | (awAddr_r == `SXS_OFF_WDOG);
  assign wMapped   = selAcc | selStatus | selInstr | selPwr | selFile | selRo;
  assign lane0     = wStrb_r[0];
  assign laneInstr = &wStrb_r[2:0];

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [7:0] accR;
  logic [7:0] fileR [128];
  logic       carryR, digitR, zeroR, tmoutNR, pwrdnNR;
  logic [7:0] wdogCnt_r, wdogPre_r;
  sxs_pwr_e   pwrState_r, pwrState_nxt;
  logic [7:0] dirA_r, dirB_r, dirC_r;
  logic [31:0] instr_r;

  // --------------------------------------------------------------------------
  // instruction fields and datapath
  // --------------------------------------------------------------------------
  sxs_op_e    opSel;
  logic       destF;
  logic [6:0] fAddr;
  logic [7:0] litK, fVal, subA, subDiff, res;
  logic       subCin, digitOut, carryOut, exec;
  logic       wrAcc, wrFile, updCarry, updZero, wrDir, goSleep;

  assign opSel  = sxs_op_e'(wData_r[3:0]);
  assign destF  = wData_r[`SXS_IN_DEST];
  assign fAddr  = wData_r[`SXS_IN_F_LSB +: 7];
  assign litK   = wData_r[`SXS_IN_K_LSB +: 8];
  assign fVal   = fileR[fAddr];
  assign exec   = doWrite & selInstr & laneInstr & (pwrState_r == PWR_RUN);
  assign subA   = (opSel == OP_LIT_MINUS) ? litK : fVal;
  assign subCin = (opSel == OP_REG_BORROW) ? carryR : 1'b1;

  // low slice gives digit carry, high slice gives carry
  sxs_nib_sub #(.W(4)) uLowNib (
    .minuend    (subA[3:0]),
    .subtrahend (accR[3:0]),
    .carryIn    (subCin),
    .diff       (subDiff[3:0]),
    .carryOut   (digitOut)
  );
  sxs_nib_sub #(.W(4)) uHighNib (
    .minuend    (subA[7:4]),
    .subtrahend (accR[7:4]),
    .carryIn    (digitOut),
    .diff       (subDiff[7:4]),
    .carryOut   (carryOut)
  );

  always_comb begin
    res      = 8'h00;
    wrAcc    = 1'b0;
    wrFile   = 1'b0;
    updCarry = 1'b0;
    updZero  = 1'b0;
    wrDir    = 1'b0;
    goSleep  = 1'b0;
    unique case (opSel)
      OP_NOP: begin
      end
      OP_LIT_MINUS: begin
        res      = subDiff;
        wrAcc    = 1'b1;
        updCarry = 1'b1;
        updZero  = 1'b1;
      end
      OP_REG_MINUS, OP_REG_BORROW: begin
        res      = subDiff;
        wrAcc    = ~destF;
        wrFile   = destF;
        updCarry = 1'b1;
        updZero  = 1'b1;
      end
      OP_NIB_SWAP: begin
        res    = {fVal[3:0], fVal[7:4]};
        wrAcc  = ~destF;
        wrFile = destF;
      end
      OP_XOR_LIT: begin
        res     = accR ^ litK;
        wrAcc   = 1'b1;
        updZero = 1'b1;
      end
      OP_XOR_REG: begin
        res     = accR ^ fVal;
        wrAcc   = ~destF;
        wrFile  = destF;
        updZero = 1'b1;
      end
      OP_DIR_LOAD: begin
        wrDir = 1'b1;
      end
      OP_SLEEP: begin
        goSleep = 1'b1;
      end
      default: begin
      end
    endcase
  end

  logic execSleep, swWake;
  assign execSleep = exec & goSleep;
  assign swWake    = doWrite & selPwr & lane0 & wData_r[`SXS_PWR_WAKE];

  always_comb begin
    pwrState_nxt = pwrState_r;
    unique case (pwrState_r)
      PWR_RUN:   if (execSleep) pwrState_nxt = PWR_SLEEP;
      PWR_SLEEP: if (wakeRequest | swWake) pwrState_nxt = PWR_RUN;
    endcase
  end
  assign oscRun = pwrState_r == PWR_RUN;

  // --------------------------------------------------------------------------
  // bus handshake flops
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 12'h000;
      wHeld_r  <= 1'b0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r  <= `SXS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[11:2], 2'b00};
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid & ~wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
      if (doWrite) begin
        bValid_r <= 1'b1;
        bResp_r  <= wMapped ? `SXS_RESP_OKAY : `SXS_RESP_DECERR;
      end else if (s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  logic [11:0] rAddr;
  logic [31:0] rdMux;
  logic        rMapped;
  assign rAddr   = {s_axi_araddr[11:2], 2'b00};
  assign rMapped = (rAddr[11:9] == `SXS_FILE_REGION) | (rAddr <= `SXS_OFF_PWR);
  assign rdMux   =
      (rAddr[11:9] == `SXS_FILE_REGION) ? {24'h000000, fileR[rAddr[8:2]]} :
      (rAddr == `SXS_OFF_ACC)    ? {24'h000000, accR} :
      (rAddr == `SXS_OFF_STATUS) ? {27'h0000000, tmoutNR, pwrdnNR, zeroR, digitR, carryR} :
      (rAddr == `SXS_OFF_INSTR)  ? instr_r :
      (rAddr == `SXS_OFF_DIR_A)  ? {24'h000000, dirA_r} :
      (rAddr == `SXS_OFF_DIR_B)  ? {24'h000000, dirB_r} :
      (rAddr == `SXS_OFF_DIR_C)  ? {24'h000000, dirC_r} :
      (rAddr == `SXS_OFF_WDOG)   ? {16'h0000, wdogPre_r, wdogCnt_r} :
      (rAddr == `SXS_OFF_PWR)    ? {30'h00000000, pwrState_r == PWR_SLEEP, 1'b0} :
      32'h0000_0000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= `SXS_RESP_OKAY;
    end else if (arTake) begin
      rValid_r <= 1'b1;
      rData_r  <= rdMux;
      rResp_r  <= rMapped ? `SXS_RESP_OKAY : `SXS_RESP_DECERR;
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // architectural state
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accR    <= `SXS_RST_BYTE;
      instr_r <= 32'h0000_0000;
    end else if (exec & wrAcc) begin
      accR    <= res;
      instr_r <= wData_r;
    end else if (exec) begin
      instr_r <= wData_r;
    end else if (doWrite & selAcc & lane0) begin
      accR <= wData_r[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 128; i++) begin
        fileR[i] <= `SXS_RST_BYTE;
      end
    end else if (exec & wrFile) begin
      fileR[fAddr] <= res;
    end else if (doWrite & selFile & lane0) begin
      fileR[awAddr_r[8:2]] <= wData_r[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      carryR  <= 1'b0;
      digitR  <= 1'b0;
      zeroR   <= 1'b0;
      tmoutNR <= `SXS_RST_TMOUT;
      pwrdnNR <= `SXS_RST_PWRDN;
    end else if (exec) begin
      if (updCarry) begin
        carryR <= carryOut;
        digitR <= digitOut;
      end
      if (updZero) zeroR <= res == 8'h00;
      if (goSleep) begin
        tmoutNR <= 1'b1;
        pwrdnNR <= 1'b0;
      end
    end else if (doWrite & selStatus & lane0) begin
      carryR <= wData_r[`SXS_ST_CARRY];
      digitR <= wData_r[`SXS_ST_DIGIT];
      zeroR  <= wData_r[`SXS_ST_ZERO];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dirA_r <= `SXS_RST_DIR;
      dirB_r <= `SXS_RST_DIR;
      dirC_r <= `SXS_RST_DIR;
    end else if (exec & wrDir) begin
      if (fAddr == `SXS_SEL_DIR_A) dirA_r <= accR;
      if (fAddr == `SXS_SEL_DIR_B) dirB_r <= accR;
      if (fAddr == `SXS_SEL_DIR_C) dirC_r <= accR;
    end
  end
  assign portADir = dirA_r;
  assign portBDir = dirB_r;
  assign portCDir = dirC_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdogPre_r  <= 8'h00;
      wdogCnt_r  <= 8'h00;
      pwrState_r <= PWR_RUN;
    end else begin
      pwrState_r <= pwrState_nxt;
      if (execSleep) begin
        wdogPre_r <= 8'h00;
        wdogCnt_r <= 8'h00;
      end else begin
        wdogPre_r <= wdogPre_r + 8'h01;
        if (wdogPre_r == `SXS_WDOG_PRE_LAST) wdogCnt_r <= wdogCnt_r + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  property p_litSub;
    @(posedge clock) disable iff (rst)
    (exec && opSel == OP_LIT_MINUS) |=> accR == ($past(litK) - $past(accR));
  endproperty
  a_litSub: assert property (p_litSub) else $error("literal subtract result wrong");

  property p_subFlags;
    @(posedge clock) disable iff (rst)
    (exec && opSel == OP_LIT_MINUS) |=> (carryR == ($past(accR) <= $past(litK)))
      && (digitR == ($past(accR[3:0]) <= $past(litK[3:0])));
  endproperty
  a_subFlags: assert property (p_subFlags) else $error("subtract flags wrong");

  property p_sleepStat;
    @(posedge clock) disable iff (rst)
    execSleep |=> tmoutNR && !pwrdnNR && $stable(carryR) && $stable(zeroR) && $stable(digitR);
  endproperty
  a_sleepStat: assert property (p_sleepStat) else $error("sleep status bits wrong");

  property p_sleepWdog;
    @(posedge clock) disable iff (rst)
    execSleep |=> (wdogCnt_r == 8'h00 && wdogPre_r == 8'h00) ##1 wdogPre_r == 8'h01;
  endproperty
  a_sleepWdog: assert property (p_sleepWdog) else $error("watchdog not cleared");

  property p_sleepOsc;
    @(posedge clock) disable iff (rst)
    (execSleep || (!oscRun && !wakeRequest && !swWake)) |=> !oscRun;
  endproperty
  a_sleepOsc: assert property (p_sleepOsc) else $error("oscillator not halted");

  property p_regSub;
    @(posedge clock) disable iff (rst)
    (exec && opSel == OP_REG_MINUS && !destF) |=> accR == ($past(fVal) - $past(accR));
  endproperty
  a_regSub: assert property (p_regSub) else $error("register subtract wrong");

  property p_borrow;
    @(posedge clock) disable iff (rst)
    (exec && opSel == OP_REG_BORROW && !destF)
      |=> accR == ($past(fVal) - $past(accR) - {7'h00, ~$past(carryR)});
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow subtract wrong");

  property p_swap;
    @(posedge clock) disable iff (rst)
    (exec && opSel == OP_NIB_SWAP && destF)
      |=> fileR[$past(fAddr)] == {$past(fVal[3:0]), $past(fVal[7:4])} && $stable(zeroR)
      && $stable(carryR);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_dest;
    @(posedge clock) disable iff (rst)
    (exec && opSel == OP_REG_MINUS && destF)
      |=> $stable(accR) && fileR[$past(fAddr)] == ($past(fVal) - $past(accR));
  endproperty
  a_dest: assert property (p_dest) else $error("destination routing wrong");

  property p_xorLit;
    @(posedge clock) disable iff (rst)
    (exec && opSel == OP_XOR_LIT) |=> accR == ($past(accR) ^ $past(litK)) && $stable(carryR);
  endproperty
  a_xorLit: assert property (p_xorLit) else $error("literal xor wrong");

  property p_dirLoad;
    @(posedge clock) disable iff (rst)
    (exec && opSel == OP_DIR_LOAD && fAddr == `SXS_SEL_DIR_B)
      |=> portBDir == $past(accR) && $stable(portADir) && $stable(zeroR);
  endproperty
  a_dirLoad: assert property (p_dirLoad) else $error("direction load wrong");

  property p_xorReg;
    @(posedge clock) disable iff (rst)
    (exec && opSel == OP_XOR_REG && !destF)
      |=> accR == ($past(accR) ^ $past(fVal)) && $stable(digitR);
  endproperty
  a_xorReg: assert property (p_xorReg) else $error("register xor wrong");

  property p_zero;
    @(posedge clock) disable iff (rst)
    (exec && updZero) |=> zeroR == ($past(res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule // sxs_exec

`default_nettype wire

// ### sxs_exec_tb.sv
`default_nettype none
`include "sxs_consts.svh"

module sxs_exec_tb import sxs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        wakeRequest = 1'b0;
  logic        oscRun;
  logic [7:0]  portADir;
  logic [7:0]  portBDir;
  logic [7:0]  portCDir;
  int          badCount = 0;
  int          comparisons = 0;
  int          cycles = 0;

  sxs_exec u_sxs_exec (
    .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wakeRequest, .oscRun,
    .portADir, .portBDir, .portCDir
  );

  initial begin
    forever #5 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      stopTest();
    end
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic stopTest();
    if (badCount == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic gotB;
    gotB = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!gotB) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        gotB = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic gotR;
    gotR = 1'b0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!gotR) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        gotR = 1'b1;
      end
    end
  endtask

  task automatic wrOk(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chkResp(r, `SXS_RESP_OKAY);
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chkResp(r, `SXS_RESP_OKAY);
    chkData(d & m, exp);
  endtask

  function automatic logic [11:0] fa(input logic [6:0] f);
    return {`SXS_FILE_REGION, f, 2'b00};
  endfunction

  task automatic ex(input sxs_op_e op, input logic d, input logic [6:0] f, input logic [7:0] k);
    wrOk(`SXS_OFF_INSTR, {8'h00, k, 1'b0, f, d, 3'b000, op});
  endtask

  // preset file, acc and flags, run one op, judge result and flags
  task automatic doOp(input sxs_op_e op, input logic d, input logic [6:0] f,
                      input logic [7:0] fv, input logic [7:0] w, input logic [7:0] k,
                      input logic [2:0] pre, input logic [7:0] res, input logic [2:0] st);
    wrOk(fa(f), {24'h0, fv});
    wrOk(`SXS_OFF_ACC, {24'h0, w});
    wrOk(`SXS_OFF_STATUS, {29'h0, pre});
    ex(op, d, f, k);
    rdChk(d ? fa(f) : `SXS_OFF_ACC, {24'h0, res}, 32'hFF);
    rdChk(`SXS_OFF_STATUS, {29'h0, st}, 32'h7);
    if (d) rdChk(`SXS_OFF_ACC, {24'h0, w}, 32'hFF);
  endtask

  // a is the literal or the file value; cin is carry, used as not-borrow
  task automatic subCase(input sxs_op_e op, input logic d, input logic [6:0] f,
                         input logic [7:0] a, input logic [7:0] w, input logic cin);
    logic [8:0] full;
    logic [4:0] nib;
    logic       b;
    b = (op == OP_REG_BORROW) ? ~cin : 1'b0;
    full = {1'b0, a} - {1'b0, w} - b;
    nib = {1'b0, a[3:0]} - {1'b0, w[3:0]} - b;
    doOp(op, d, f, a, w, a, {full[7:0] != 0, nib[4], cin}, full[7:0],
         {full[7:0] == 0, ~nib[4], ~full[8]});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    chkData(portADir, `SXS_RST_DIR);
    chkData(portBDir, `SXS_RST_DIR);
    chkData(portCDir, `SXS_RST_DIR);
    chkData(oscRun, 1'b1);
    rdChk(`SXS_OFF_STATUS, 32'h18, 32'h18);
  endtask

  task automatic testSub();
    subCase(OP_LIT_MINUS, 0, 7'h00, 8'h03, 8'h05, 1);
    subCase(OP_LIT_MINUS, 0, 7'h00, 8'h3A, 8'h3A, 0);
    subCase(OP_LIT_MINUS, 0, 7'h00, 8'h20, 8'h01, 0);
    subCase(OP_REG_MINUS, 0, 7'h7F, 8'h80, 8'h7F, 0);
    subCase(OP_REG_MINUS, 1, 7'h00, 8'h10, 8'h11, 1);
    subCase(OP_REG_BORROW, 1, 7'h15, 8'h10, 8'h0F, 0);
    subCase(OP_REG_BORROW, 0, 7'h15, 8'h00, 8'h00, 1);
    subCase(OP_REG_BORROW, 0, 7'h16, 8'h00, 8'h00, 0);
  endtask

  task automatic testLogic();
    doOp(OP_NIB_SWAP, 1, 7'h22, 8'hA5, 8'h11, 0, 3'b010, 8'h5A, 3'b010);
    doOp(OP_NIB_SWAP, 0, 7'h23, 8'h00, 8'h11, 0, 3'b001, 8'h00, 3'b001);
    doOp(OP_XOR_LIT, 0, 7'h00, 8'h00, 8'h5C, 8'h5C, 3'b011, 8'h00, 3'b111);
    doOp(OP_XOR_LIT, 0, 7'h00, 8'h00, 8'h0F, 8'hF0, 3'b111, 8'hFF, 3'b011);
    doOp(OP_XOR_REG, 1, 7'h40, 8'h33, 8'h33, 0, 3'b000, 8'h00, 3'b100);
    doOp(OP_XOR_REG, 0, 7'h41, 8'h81, 8'h01, 0, 3'b101, 8'h80, 3'b001);
  endtask

  task automatic testDir();
    wrOk(`SXS_OFF_STATUS, 32'h5);
    for (int i = 7; i >= 4; i--) begin
      wrOk(`SXS_OFF_ACC, 32'hC0 + i);
      ex(OP_DIR_LOAD, 0, i[6:0], 0);
    end
    chkData(portADir, 8'hC5);
    chkData(portBDir, 8'hC6);
    chkData(portCDir, 8'hC7);
    rdChk(`SXS_OFF_DIR_A, 32'hC5, 32'hFF);
    rdChk(`SXS_OFF_STATUS, 32'h5, 32'h7);
  endtask

  task automatic testMap();
    logic [31:0] d;
    logic [1:0]  r;
    rd(12'h100, d, r);
    chkResp(r, `SXS_RESP_DECERR);
    chkData(d, 32'h0);
    wr(12'h100, 32'h1, r);
    chkResp(r, `SXS_RESP_DECERR);
    wrOk(`SXS_OFF_DIR_B, 32'h12);
    chkData(portBDir, 8'hC6);
  endtask

  task automatic testSleep();
    int n;
    wrOk(`SXS_OFF_STATUS, 32'h7);
    wrOk(`SXS_OFF_ACC, 32'h3C);
    ex(OP_SLEEP, 0, 0, 0);
    chkData(oscRun, 1'b0);
    rdChk(`SXS_OFF_STATUS, 32'h17, 32'h1F);
    rdChk(`SXS_OFF_WDOG, 32'h0, 32'hF0FF);
    rdChk(`SXS_OFF_PWR, 32'h2, 32'h2);
    ex(OP_XOR_LIT, 0, 0, 8'hFF);
    rdChk(`SXS_OFF_ACC, 32'h3C, 32'hFF);
    @(posedge clock);
    wakeRequest <= 1'b1;
    @(posedge clock);
    wakeRequest <= 1'b0;
    n = 0;
    while (oscRun !== 1'b1 && n < 10) begin
      @(posedge clock);
      n++;
    end
    chkData(oscRun, 1'b1);
    rdChk(`SXS_OFF_STATUS, 32'h17, 32'h1F);
    // second sleep, left by a software wake
    ex(OP_SLEEP, 0, 0, 0);
    chkData(oscRun, 1'b0);
    rdChk(`SXS_OFF_PWR, 32'h2, 32'h2);
    wrOk(`SXS_OFF_PWR, 32'h1);
    chkData(oscRun, 1'b1);
    rdChk(`SXS_OFF_PWR, 32'h0, 32'h2);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    testReset();
    testSub();
    testLogic();
    testDir();
    testMap();
    testSleep();
    stopTest();
  end

endmodule // sxs_exec_tb

`default_nettype wire

// ### sxs_nib_sub.sv
`default_nettype none

// one slice of minuend minus subtrahend, carry high means no borrow
module sxs_nib_sub #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] minuend,
  input  wire logic [W-1:0] subtrahend,
  input  wire logic         carryIn,
  output logic      [W-1:0] diff,
  output logic              carryOut
);

  logic [W:0] sum;

  assign sum      = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, carryIn};
  assign diff     = sum[W-1:0];
  assign carryOut = sum[W];

endmodule // sxs_nib_sub

`default_nettype wire

// ### sxs_pkg.sv
`default_nettype none
`include "sxs_consts.svh"

package sxs_pkg;

  typedef enum logic [3:0] {
    OP_NOP        = `SXS_OP_NOP,
    OP_LIT_MINUS  = `SXS_OP_LITSUB,
    OP_REG_MINUS  = `SXS_OP_REGSUB,
    OP_REG_BORROW = `SXS_OP_REGSUBB,
    OP_NIB_SWAP   = `SXS_OP_SWAP,
    OP_XOR_LIT    = `SXS_OP_XORLIT,
    OP_XOR_REG    = `SXS_OP_XORREG,
    OP_DIR_LOAD   = `SXS_OP_DIRLOAD,
    OP_SLEEP      = `SXS_OP_SLEEP
  } sxs_op_e;

  typedef enum logic {
    PWR_RUN   = 1'b0,
    PWR_SLEEP = 1'b1
  } sxs_pwr_e;

endpackage

`default_nettype wire
